// file: tsm_pkg.sv
// constants shared by the transport stream serialiser and monitor
package tsm_pkg;
  // clock and timing
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          LOSS_TIME_NS = 20_000;
  localparam int          LOSS_CYC     = (LOSS_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int          LOSS_W       = $clog2(LOSS_CYC + 1);
  localparam int          HOLD_MS      = 300;
  localparam int          HOLD_CYC     = HOLD_MS * (CLK_HZ / 1000);
  // packet sync supervision
  localparam logic [7:0]  LEN_SHORT    = 8'hbc;  // 188 bytes
  localparam logic [7:0]  LEN_LONG     = 8'hcc;  // 204 bytes
  localparam logic [1:0]  MISS_LIMIT   = 2'h2;
  localparam logic [2:0]  GOOD_LIMIT   = 3'h5;
  // line coder tokens
  localparam logic [1:0]  TOK_SPACE    = 2'h0;
  localparam logic [1:0]  TOK_MARK     = 2'h1;
  localparam logic [1:0]  TOK_B        = 2'h2;
  localparam logic [1:0]  TOK_V        = 2'h3;
  // stream serial link
  localparam logic [7:0]  K28_5        = 8'hbc;
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  // register map (byte addresses)
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATE    = 8'h04;
  localparam logic [7:0]  REG_EVT      = 8'h08;
  localparam logic [7:0]  REG_EVT_CLR  = 8'h0c;
  localparam logic [7:0]  REG_EVT_EN   = 8'h10;
  localparam logic [7:0]  REG_LEN      = 8'h14;
  localparam logic        CTRL_RST     = 1'h0;   // 0 = four zero, 1 = three zero code
  localparam logic [3:0]  EVT_EN_RST   = 4'h0;
  // event bit positions
  localparam int          EV_LOSS      = 0;
  localparam int          EV_ERR_SET   = 1;
  localparam int          EV_ERR_CLR   = 2;
  localparam int          EV_LEN       = 3;
  localparam int          EV_N         = 4;
endpackage

// file: tsm_top.sv
// transport stream parallel to serial adapter with stream monitor
// Operation
// R1 - serialise stream unchanged, find packet syncs
// R2 - line bit rate equals input payload rate
// R3 - source supplies data at the line rate
// R4 - stream link sends 8b10b characters, comma fill
// R5 - packet bytes sent in bursts, commas between
// R6 - input loss when byte clock stops
// R7 - parallel output off during input loss
// R8 - line output off during input loss
// R9 - two missed syncs declare sync error
// R10 - five good syncs clear sync error
// R11 - sync lamp held 300 ms after clear
// R12 - short indicator on 188 byte spacing
// R13 - long indicator on 204 byte spacing
// R14 - relay driven on loss or sync error
// R15 - byte fields taken at byte clock rise; the code catches them at the fall and uses them at the next rise
// R16 - source flags filler bytes as not valid
// R17 - four zero substitution, alternating violations
// R18 - three zero substitution, odd b count
// R19 - count bytes between packet start markers
`timescale 1ns/1ps
module tsm_top #(
  parameter int SYNC_HOLD_CYCLES = tsm_pkg::HOLD_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  input  wire logic        byte_clk_i,
  input  wire logic [7:0]  byte_data_i,
  input  wire logic        packet_start_marker_i,
  input  wire logic        byte_valid_flag_i,
  input  wire logic        relay_sense_link_i,
  output logic      [7:0]  par_data_o,
  output logic             par_start_o,
  output logic             par_valid_o,
  output logic             par_oe_o,
  output logic             line_pos_o,
  output logic             line_neg_o,
  output logic      [7:0]  asi_char_o,
  output logic             asi_k_o,
  output logic             loss_led_o,
  output logic             sync_led_o,
  output logic             short_led_o,
  output logic             long_led_o,
  output logic             relay_o
);
  localparam int HW = $clog2(SYNC_HOLD_CYCLES + 1);

  // a zero hold time would leave the lamp counter without a width
  if (SYNC_HOLD_CYCLES < 1) begin : g_bad_hold
    $error("SYNC_HOLD_CYCLES must be at least 1");
  end

  // two-stage synchronisers: {sense, valid, start, data, clk}
  logic [11:0] s1_r, s2_r;
  logic        bclk_d_r;
  logic [9:0]  cap_r;  // {valid, start, data} caught mid-period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r     <= 12'h000;
      s2_r     <= 12'h000;
      bclk_d_r <= 1'h0;
      cap_r    <= 10'h000;
    end else begin
      s1_r     <= {relay_sense_link_i, byte_valid_flag_i, packet_start_marker_i,
                   byte_data_i, byte_clk_i};
      s2_r     <= s1_r;
      bclk_d_r <= s2_r[0];
      // fields are stable at the falling edge, so catch them there
      if (bclk_d_r && !s2_r[0]) cap_r <= s2_r[10:1];
    end
  end

  logic bclk_rise, bclk_edge;
  assign bclk_rise = s2_r[0] && !bclk_d_r;  // R15
  assign bclk_edge = s2_r[0] ^ bclk_d_r;

  // monitor state
  localparam int LOSS_W_T = tsm_pkg::LOSS_W;
  logic [LOSS_W_T-1:0] lcnt_r, lcnt_nxt;
  logic        loss_r, loss_nxt;
  logic [7:0]  cnt_r, cnt_nxt, exp_r, exp_nxt, idx;
  logic [1:0]  miss_r, miss_nxt;
  logic [2:0]  good_r, good_nxt;
  logic        err_r, err_nxt, led_r, led_nxt, s188_r, s188_nxt, s204_r, s204_nxt;
  logic [HW-1:0] hold_r, hold_nxt;
  logic        stb, missed;

  assign stb = bclk_rise && !loss_r;
  assign idx = cnt_r + 8'h01;

  // loss watchdog, packet length and sync supervision
  always_comb begin
    lcnt_nxt = lcnt_r;
    loss_nxt = loss_r;
    cnt_nxt  = cnt_r;
    exp_nxt  = exp_r;
    miss_nxt = miss_r;
    good_nxt = good_r;
    err_nxt  = err_r;
    s188_nxt = s188_r;
    s204_nxt = s204_r;
    missed   = 1'b0;
    if (bclk_edge) begin
      lcnt_nxt = '0;
      loss_nxt = 1'b0;
    end else if (lcnt_r == LOSS_W_T'(tsm_pkg::LOSS_CYC - 1)) begin
      loss_nxt = 1'b1;  // R6
    end else begin
      lcnt_nxt = lcnt_r + 1'b1;
    end
    if (stb) begin
      if (cap_r[8]) begin  // R19
        cnt_nxt = 8'h00;
        if (idx == tsm_pkg::LEN_SHORT || idx == tsm_pkg::LEN_LONG) begin
          exp_nxt  = idx;
          s188_nxt = (idx == tsm_pkg::LEN_SHORT);  // R12
          s204_nxt = (idx == tsm_pkg::LEN_LONG);   // R13
          miss_nxt = 2'h0;
          if (good_r != tsm_pkg::GOOD_LIMIT) good_nxt = good_r + 3'h1;
        end else if (exp_r != 8'h00) begin
          missed = 1'b1;  // sync in the wrong place
        end
      end else if (exp_r != 8'h00 && idx == exp_r) begin
        missed  = 1'b1;   // expected sync position passed empty
        cnt_nxt = 8'h00;
      end else begin
        cnt_nxt = idx;
      end
    end
    if (missed) begin
      good_nxt = 3'h0;
      if (miss_r != tsm_pkg::MISS_LIMIT) miss_nxt = miss_r + 2'h1;
    end
    if (err_r && good_nxt == tsm_pkg::GOOD_LIMIT) err_nxt = 1'b0;  // R10
    if (miss_nxt == tsm_pkg::MISS_LIMIT) begin
      err_nxt  = 1'b1;  // R9
      good_nxt = 3'h0;
    end
    if (err_nxt || loss_nxt) begin
      s188_nxt = 1'b0;
      s204_nxt = 1'b0;
    end
    if (loss_nxt) begin
      cnt_nxt = 8'h00;
      exp_nxt = 8'h00;
    end
    // lamp stays lit a fixed time after the error clears
    if (err_nxt) hold_nxt = HW'(SYNC_HOLD_CYCLES);  // R11
    else if (hold_r != '0) hold_nxt = hold_r - 1'b1;
    else hold_nxt = hold_r;
    led_nxt = err_nxt || (hold_nxt != '0);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lcnt_r <= '0;
      loss_r <= 1'h1;  // nothing seen yet counts as lost
      cnt_r  <= 8'h00;
      exp_r  <= 8'h00;
      miss_r <= 2'h0;
      good_r <= 3'h0;
      err_r  <= 1'h0;
      led_r  <= 1'h0;
      s188_r <= 1'h0;
      s204_r <= 1'h0;
      hold_r <= '0;
    end else begin
      lcnt_r <= lcnt_nxt;
      loss_r <= loss_nxt;
      cnt_r  <= cnt_nxt;
      exp_r  <= exp_nxt;
      miss_r <= miss_nxt;
      good_r <= good_nxt;
      err_r  <= err_nxt;
      led_r  <= led_nxt;
      s188_r <= s188_nxt;
      s204_r <= s204_nxt;
      hold_r <= hold_nxt;
    end
  end

  // serialiser and zero substitution line coder
  logic [7:0]  sh_r, sh_nxt;
  logic [3:0]  bits_r, bits_nxt;
  logic [1:0]  tok_r [4];
  logic [1:0]  tok_nxt [4];
  logic [1:0]  zc_r, zc_nxt, zlim;
  logic        par_r, par_nxt, pol_r, pol_nxt, pos_nxt, neg_nxt, bit_v, ctrl_r;
  assign bit_v = (bits_r != 4'h0);
  assign zlim  = ctrl_r ? 2'h2 : 2'h3;

  always_comb begin
    sh_nxt   = sh_r;
    bits_nxt = bits_r;
    tok_nxt  = tok_r;
    zc_nxt   = zc_r;
    par_nxt  = par_r;
    pol_nxt  = pol_r;
    pos_nxt  = 1'b0;
    neg_nxt  = 1'b0;
    if (bit_v) begin
      // one bit per clock: a byte every eight clocks keeps the rate
      sh_nxt   = {sh_r[6:0], 1'b0};  // R1 R2
      bits_nxt = bits_r - 4'h1;
      case (tok_r[3])
        tsm_pkg::TOK_MARK, tsm_pkg::TOK_B: begin
          pos_nxt = !pol_r;
          neg_nxt = pol_r;
          pol_nxt = !pol_r;
        end
        tsm_pkg::TOK_V: begin  // same polarity as the last pulse
          pos_nxt = pol_r;
          neg_nxt = !pol_r;
        end
        default: begin
          pos_nxt = 1'b0;
          neg_nxt = 1'b0;
        end
      endcase
      tok_nxt[3] = tok_r[2];
      tok_nxt[2] = tok_r[1];
      tok_nxt[1] = tok_r[0];
      if (sh_r[7]) begin
        tok_nxt[0] = tsm_pkg::TOK_MARK;
        zc_nxt     = 2'h0;
        par_nxt    = !par_r;
      end else if (zc_r == zlim) begin
        tok_nxt[0] = tsm_pkg::TOK_V;
        zc_nxt     = 2'h0;
        par_nxt    = 1'b0;
        // even pulse count since last violation needs a balancing pulse
        if (!par_r && ctrl_r) tok_nxt[2] = tsm_pkg::TOK_B;  // R18
        if (!par_r && !ctrl_r) tok_nxt[3] = tsm_pkg::TOK_B; // R17
      end else begin
        tok_nxt[0] = tsm_pkg::TOK_SPACE;
        zc_nxt     = zc_r + 2'h1;
      end
    end
    if (stb) begin
      sh_nxt   = cap_r[7:0];
      bits_nxt = tsm_pkg::BYTE_BITS;
    end
    if (loss_r) begin  // R8
      bits_nxt = 4'h0;
      pos_nxt  = 1'b0;
      neg_nxt  = 1'b0;
    end
  end

  logic line_pos_r, line_neg_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_r       <= 8'h00;
      bits_r     <= 4'h0;
      tok_r      <= '{default: tsm_pkg::TOK_SPACE};
      zc_r       <= 2'h0;
      par_r      <= 1'h0;
      pol_r      <= 1'h0;
      line_pos_r <= 1'h0;
      line_neg_r <= 1'h0;
    end else begin
      sh_r       <= sh_nxt;
      bits_r     <= bits_nxt;
      tok_r      <= tok_nxt;
      zc_r       <= zc_nxt;
      par_r      <= par_nxt;
      pol_r      <= pol_nxt;
      line_pos_r <= pos_nxt;
      line_neg_r <= neg_nxt;
    end
  end

  // packet double buffer feeding the stream link in bursts
  logic [7:0] mem [512];
  logic       wb_bank_r, wb_bank_nxt, rd_bank_r, rd_bank_nxt, busy_r, busy_nxt, wr_en;
  logic [7:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt, rd_len_r, rd_len_nxt;
  always_comb begin
    wb_bank_nxt = wb_bank_r;
    wr_ptr_nxt  = wr_ptr_r;
    rd_bank_nxt = rd_bank_r;
    rd_ptr_nxt  = rd_ptr_r;
    rd_len_nxt  = rd_len_r;
    busy_nxt    = busy_r;
    wr_en       = 1'b0;
    if (busy_r) begin  // R5
      rd_ptr_nxt = rd_ptr_r + 8'h01;
      if (rd_ptr_nxt == rd_len_r) busy_nxt = 1'b0;
    end
    if (stb) begin
      if (cap_r[8] && wr_ptr_r != 8'h00) begin
        rd_bank_nxt = wb_bank_r;  // whole packet stored: launch burst
        rd_len_nxt  = wr_ptr_r;
        rd_ptr_nxt  = 8'h00;
        busy_nxt    = 1'b1;
        wb_bank_nxt = !wb_bank_r;
        wr_ptr_nxt  = 8'h00;
      end
      // filler bytes carry no payload and are left out of the burst
      if (cap_r[9] && wr_ptr_nxt != 8'hff) begin
        wr_en      = 1'b1;
        wr_ptr_nxt = wr_ptr_nxt + 8'h01;
      end
    end
    if (loss_r) wr_ptr_nxt = 8'h00;
  end

  logic [7:0] asi_char_r;
  logic       asi_k_r;
  always_ff @(posedge clk_i) begin
    if (wr_en) mem[{wb_bank_nxt, wr_ptr_nxt - 8'h01}] <= cap_r[7:0];
    if (rst_i) begin
      wb_bank_r  <= 1'h0;
      wr_ptr_r   <= 8'h00;
      rd_bank_r  <= 1'h0;
      rd_ptr_r   <= 8'h00;
      rd_len_r   <= 8'h00;
      busy_r     <= 1'h0;
      asi_char_r <= tsm_pkg::K28_5;
      asi_k_r    <= 1'h1;
    end else begin
      wb_bank_r  <= wb_bank_nxt;
      wr_ptr_r   <= wr_ptr_nxt;
      rd_bank_r  <= rd_bank_nxt;
      rd_ptr_r   <= rd_ptr_nxt;
      rd_len_r   <= rd_len_nxt;
      busy_r     <= busy_nxt;
      asi_char_r <= busy_r ? mem[{rd_bank_r, rd_ptr_r}] : tsm_pkg::K28_5;  // R4
      asi_k_r    <= !busy_r;
    end
  end

  // register slave, events and alarm outputs
  logic [tsm_pkg::EV_N-1:0] evt_r, evt_nxt, en_r, en_nxt, ev_set, ev_clr;
  logic [31:0] rdat_nxt, rdat_r;
  logic        ack_r, req, wr, ctrl_nxt, relay_r;
  logic [10:0] par_r_o;
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  // write lands at the edge where the master sees ack, request still held
  assign wr  = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0];
  always_comb begin
    ev_set = '0;
    ev_set[tsm_pkg::EV_LOSS]    = loss_nxt && !loss_r;
    ev_set[tsm_pkg::EV_ERR_SET] = err_nxt && !err_r;
    ev_set[tsm_pkg::EV_ERR_CLR] = !err_nxt && err_r;
    ev_set[tsm_pkg::EV_LEN]     = (s188_nxt != s188_r) || (s204_nxt != s204_r);
    ev_clr   = (wr && wb_adr_i == tsm_pkg::REG_EVT_CLR) ? wb_dat_i[tsm_pkg::EV_N-1:0] : '0;
    evt_nxt  = (evt_r & ~ev_clr) | ev_set;  // a new event beats the clear
    en_nxt   = (wr && wb_adr_i == tsm_pkg::REG_EVT_EN) ? wb_dat_i[tsm_pkg::EV_N-1:0] : en_r;
    ctrl_nxt = (wr && wb_adr_i == tsm_pkg::REG_CTRL) ? wb_dat_i[0] : ctrl_r;
    case (wb_adr_i)
      tsm_pkg::REG_CTRL:   rdat_nxt = {31'h0, ctrl_r};
      tsm_pkg::REG_STATE:  rdat_nxt = {26'h0, relay_r, s204_r, s188_r, led_r, err_r, loss_r};
      tsm_pkg::REG_EVT:    rdat_nxt = {28'h0, evt_r};
      tsm_pkg::REG_EVT_EN: rdat_nxt = {28'h0, en_r};
      tsm_pkg::REG_LEN:    rdat_nxt = {24'h0, exp_r};
      default:             rdat_nxt = 32'h0;  // unmapped and write-only read zero
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r   <= 1'h0;
      rdat_r  <= 32'h0;
      evt_r   <= '0;
      en_r    <= tsm_pkg::EVT_EN_RST;
      ctrl_r  <= tsm_pkg::CTRL_RST;
      irq_o   <= 1'h0;
      relay_r <= 1'h0;
      par_r_o <= 11'h000;
    end else begin
      ack_r   <= req;
      rdat_r  <= rdat_nxt;
      evt_r   <= evt_nxt;
      en_r    <= en_nxt;
      ctrl_r  <= ctrl_nxt;
      irq_o   <= |(evt_nxt & en_nxt);
      // sense link picks normally open or normally closed drive
      relay_r <= (loss_nxt || err_nxt) ^ s2_r[11];  // R14
      par_r_o <= loss_r ? 11'h000 : {1'b1, s2_r[10:1]};  // R7
    end
  end

  assign wb_ack_o    = ack_r;
  assign wb_dat_o    = rdat_r;
  assign relay_o     = relay_r;
  assign par_oe_o    = par_r_o[10];
  assign par_valid_o = par_r_o[9];
  assign par_start_o = par_r_o[8];
  assign par_data_o  = par_r_o[7:0];
  assign line_pos_o  = line_pos_r;
  assign line_neg_o  = line_neg_r;
  assign asi_char_o  = asi_char_r;
  assign asi_k_o     = asi_k_r;
  assign loss_led_o  = loss_r;
  assign sync_led_o  = led_r;
  assign short_led_o = s188_r;
  assign long_led_o  = s204_r;
endmodule

// file: tsm_monitor.sv
// port checker for the stream adapter, bound to its top module
`timescale 1ns/1ps
module tsm_monitor #(
  parameter int SYNC_HOLD_CYCLES = tsm_pkg::HOLD_CYC
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       byte_clk_i,
  input wire logic [7:0] byte_data_i,
  input wire logic       packet_start_marker_i,
  input wire logic       byte_valid_flag_i,
  input wire logic       relay_sense_link_i,
  input wire logic [7:0] par_data_o,
  input wire logic       par_start_o,
  input wire logic       par_valid_o,
  input wire logic       par_oe_o,
  input wire logic       line_pos_o,
  input wire logic       line_neg_o,
  input wire logic [7:0] asi_char_o,
  input wire logic       asi_k_o,
  input wire logic       loss_led_o,
  input wire logic       sync_led_o,
  input wire logic       short_led_o,
  input wire logic       long_led_o,
  input wire logic       relay_o
);
  logic [8:0]  idle_r, idle_nxt;
  logic [31:0] on_r, on_nxt;
  logic        bclk_r;
  logic [3:0]  zrun_r, zrun_nxt;
  logic [5:0]  live_r, live_nxt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // idle time of the byte clock pin, saturating; lit time of the sync lamp
  always_comb begin
    idle_nxt = (byte_clk_i != bclk_r) ? 9'h000 : idle_r + {8'h00, idle_r != 9'h1ff};
    on_nxt   = sync_led_o ? on_r + 32'h1 : 32'h0;
    // empty line slots in a row; cycles of steady byte clock without loss
    zrun_nxt = (line_pos_o || line_neg_o) ? 4'h0 : zrun_r + {3'h0, zrun_r != 4'hf};
    live_nxt = (loss_led_o || idle_r > 9'h003) ? 6'h00 : live_r + {5'h00, live_r != 6'h3f};
  end
  // helper registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_r <= 9'h000;
      on_r   <= 32'h0;
      bclk_r <= 1'b0;
      zrun_r <= 4'h0;
      live_r <= 6'h00;
    end else begin
      idle_r <= idle_nxt;
      on_r   <= on_nxt;
      bclk_r <= byte_clk_i;
      zrun_r <= zrun_nxt;
      live_r <= live_nxt;
    end
  end
  sequence s_loss_held;
    loss_led_o [*2];
  endsequence
  sequence s_alarm_held;
    (loss_led_o && $stable(relay_sense_link_i)) [*5];
  endsequence
  property p_par_off;
    s_loss_held |-> !par_oe_o && !par_start_o && par_data_o == 8'h00;
  endproperty
  a_par_off: assert property (p_par_off)
    else $error("parallel output live during loss");
  property p_line_off;
    s_loss_held |-> !line_pos_o && !line_neg_o;
  endproperty
  a_line_off: assert property (p_line_off)
    else $error("line output live during loss");
  property p_loss_set;
    idle_r == tsm_pkg::LOSS_CYC + 8 |-> loss_led_o;
  endproperty
  a_loss_set: assert property (p_loss_set)
    else $error("loss not flagged on stopped byte clock");
  property p_loss_clr;
    $fell(loss_led_o) |-> idle_r < 9'h008;
  endproperty
  a_loss_clr: assert property (p_loss_clr)
    else $error("loss cleared without byte clock");
  property p_comma;
    asi_k_o |-> asi_char_o == tsm_pkg::K28_5;
  endproperty
  a_comma: assert property (p_comma)
    else $error("control character is not a comma");
  property p_bipolar;
    !(line_pos_o && line_neg_o);
  endproperty
  a_bipolar: assert property (p_bipolar)
    else $error("both line polarities at once");
  // either substitution code leaves at most three empty slots in a row
  property p_zero_run;
    live_r == 6'h3f |-> zrun_r < 4'h4;
  endproperty
  a_zero_run: assert property (p_zero_run)
    else $error("zero run on line not substituted");
  property p_relay;
    s_alarm_held |-> relay_o == !relay_sense_link_i;
  endproperty
  a_relay: assert property (p_relay)
    else $error("relay idle during alarm");
  property p_len_off;
    $rose(sync_led_o) |-> ##[0:3] (!short_led_o && !long_led_o);
  endproperty
  a_len_off: assert property (p_len_off)
    else $error("length lamp lit in sync error");
  property p_len_one;
    !(short_led_o && long_led_o);
  endproperty
  a_len_one: assert property (p_len_one)
    else $error("both length lamps lit");
  property p_hold;
    $fell(sync_led_o) && !loss_led_o |-> on_r >= SYNC_HOLD_CYCLES;
  endproperty
  a_hold: assert property (p_hold)
    else $error("sync lamp dropped early");
  property p_par_copy;
    !loss_led_o && !$past(loss_led_o, 4) |-> par_data_o == $past(byte_data_i, 3)
      && par_start_o == $past(packet_start_marker_i, 3)
      && par_valid_o == $past(byte_valid_flag_i, 3);
  endproperty
  a_par_copy: assert property (p_par_copy)
    else $error("parallel output differs from input");
endmodule
bind tsm_top tsm_monitor #(.SYNC_HOLD_CYCLES(SYNC_HOLD_CYCLES)) u_mon (.*);

// file: tsm_source.sv
// behavioural upstream source for the parallel byte port
`timescale 1ns/1ps
module tsm_source (
  input  wire logic       run_i,
  input  wire logic       long_i,
  input  wire logic       dummy_i,
  input  wire logic       drop_i,
  output logic            byte_clk_o,
  output logic      [7:0] data_o,
  output logic            start_o,
  output logic            valid_o
);
  int idx;
  // clock stands low while stopped; data then toggles so nothing stale looks valid
  initial begin
    byte_clk_o = 1'b0;
    data_o     = 8'h00;
    start_o    = 1'b0;
    valid_o    = 1'b0;
    idx        = 0;
    #137;
    forever begin
      #400;
      if (run_i) begin
        byte_clk_o = 1'b1;
        start_o    = idx == 0 && !drop_i;
        valid_o    = !(long_i && dummy_i && idx >= 188);
        data_o     = idx == 0 ? 8'h47 : 8'($urandom);
        idx        = idx == (long_i ? 203 : 187) ? 0 : idx + 1;
        #400;
        byte_clk_o = 1'b0;
      end else begin
        data_o  = ~data_o;
        start_o = 1'b0;
        idx     = 0;
      end
    end
  end
endmodule

// file: tsm_top_bench.sv
// self-checking bench for the stream adapter
`timescale 1ns/1ps
module tsm_top_bench;
  localparam int HOLD = 50;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [7:0]  wb_adr_i, byte_data_i, par_data_o, asi_char_o;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic        byte_clk_i, packet_start_marker_i, byte_valid_flag_i, relay_sense_link_i;
  logic        par_start_o, par_valid_o, par_oe_o, line_pos_o, line_neg_o, asi_k_o;
  logic        loss_led_o, sync_led_o, short_led_o, long_led_o, relay_o;
  logic        run, lng, dmy, drp;
  logic [7:0]  first_c;
  int          err_count, total_checks, run_n, last_burst;
  tsm_top #(.SYNC_HOLD_CYCLES(HOLD)) DUT (.*);
  tsm_source SRC (.run_i(run), .long_i(lng), .dummy_i(dmy), .drop_i(drp),
    .byte_clk_o(byte_clk_i), .data_o(byte_data_i), .start_o(packet_start_marker_i),
    .valid_o(byte_valid_flag_i));
  // 10 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // length and first byte of each burst on the stream link
  initial begin
    run_n = 0;
    last_burst = 0;
  end
  always @(posedge clk_i) begin
    if (!asi_k_o && run_n == 0) first_c <= asi_char_o;
    if (!asi_k_o) run_n <= run_n + 1;
    else if (run_n != 0) begin
      last_burst <= run_n;
      run_n <= 0;
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic give_up();
    err_count++;
    $display("[FAIL] wait expected event seen none");
    report_and_stop();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic single cycle; holds the request until ack is sampled
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (n == 20) give_up();
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return loss_led_o;
      1: return short_led_o;
      2: return long_led_o;
      3: return sync_led_o;
      default: return !sync_led_o;
    endcase
  endfunction
  task automatic wait_on(input int k, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge clk_i);
      if (pick(k) === 1'b1) break;
    end
    if (n == lim) give_up();
  endtask
  function automatic logic [31:0] exp_len(input logic l);
    return {24'h0, l ? tsm_pkg::LEN_LONG : tsm_pkg::LEN_SHORT};
  endfunction
  function automatic int exp_burst(input logic l, input logic d);
    return (l && !d) ? 204 : 188;
  endfunction
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, e}, {31'h0, irq_o});
  endtask
  // reset, registers, 188 and 204 byte packets, loss, sync error
  initial begin
    void'($urandom(54));
    {wb_cyc_i, wb_stb_i, wb_we_i, run, lng, dmy, drp, relay_sense_link_i} = '0;
    {wb_adr_i, wb_dat_i, err_count, total_checks} = '0;
    wb_sel_i = 4'hf;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("loss_led", 32'h1, {31'h0, loss_led_o});
    rdc(tsm_pkg::REG_CTRL, '1, 32'h0, "ctrl");
    rdc(tsm_pkg::REG_LEN, '1, 32'h0, "len");
    rdc(8'h3c, '1, 32'h0, "unmapped");
    wb_sel_i <= 4'he;
    wr(tsm_pkg::REG_EVT_EN, 32'hf);
    wb_sel_i <= 4'hf;
    rdc(tsm_pkg::REG_EVT_EN, '1, 32'h0, "evt_en");
    wr(tsm_pkg::REG_EVT_EN, 32'hf);
    wr(tsm_pkg::REG_EVT_CLR, 32'hf);
    run <= 1'b1;
    wait_on(1, 4000);
    rdc(tsm_pkg::REG_STATE, '1, 32'h8, "state");
    rdc(tsm_pkg::REG_LEN, '1, exp_len(1'b0), "len");
    irq_is(1'b1);
    wr(tsm_pkg::REG_EVT_EN, 32'h0);
    irq_is(1'b0);
    wr(tsm_pkg::REG_EVT_EN, 32'hf);
    irq_is(1'b1);
    wr(tsm_pkg::REG_EVT_CLR, 32'hf);
    irq_is(1'b0);
    repeat (230) @(posedge clk_i);
    chk("burst", exp_burst(1'b0, 1'b0), last_burst);
    chk("first", 32'h47, {24'h0, first_c});
    run <= 1'b0;
    wait_on(0, tsm_pkg::LOSS_CYC + 40);
    @(posedge clk_i);
    chk("par_oe", 32'h0, {31'h0, par_oe_o});
    rdc(tsm_pkg::REG_EVT, 32'h1, 32'h1, "evt loss");
    irq_is(1'b1);
    relay_sense_link_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("relay", 32'h0, {31'h0, relay_o});
    relay_sense_link_i <= 1'b0;
    lng <= 1'b1;
    dmy <= 1'($urandom % 2);
    wr(tsm_pkg::REG_CTRL, 32'h1);
    rdc(tsm_pkg::REG_CTRL, '1, 32'h1, "ctrl");
    run <= 1'b1;
    wait_on(2, 5000);
    chk("short_led", 32'h0, {31'h0, short_led_o});
    rdc(tsm_pkg::REG_LEN, '1, exp_len(1'b1), "len");
    repeat (240) @(posedge clk_i);
    chk("burst", exp_burst(1'b1, dmy), last_burst);
    drp <= 1'b1;
    repeat (1200) @(posedge clk_i);
    chk("sync_led", 32'h0, {31'h0, sync_led_o});
    wait_on(3, 3500);
    chk("relay", 32'h1, {31'h0, relay_o});
    rdc(tsm_pkg::REG_STATE, 32'h2, 32'h2, "state err");
    rdc(tsm_pkg::REG_EVT, 32'h2, 32'h2, "evt err");
    drp <= 1'b0;
    repeat (6400) @(posedge clk_i);
    chk("sync_led", 32'h1, {31'h0, sync_led_o});
    wait_on(4, 9000 + HOLD);
    rdc(tsm_pkg::REG_EVT, 32'h4, 32'h4, "evt clr");
    rdc(tsm_pkg::REG_STATE, 32'h2, 32'h0, "state clr");
    report_and_stop();
  end
  // overall cycle limit
  initial begin
    repeat (100000) @(posedge clk_i);
    give_up();
  end
endmodule
